// file: hw/gst_timer.sv
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
// How it works
// - the selected counter clock passes a prescaler dividing by 1, 2, 4 or 8 before the counter moves.
// - software cannot see the prescaler, and any write to either count byte clears it.
// - with the bypass bit set the external clock edges count at once, ignoring the phase clock.
// - in asynchronous external mode counting continues in sleep and an overflow raises the wake output.
// - switching between synchronous and asynchronous counting may drop or add one increment.
// - reading a count byte always returns a whole, consistent byte.
// - gate enable clear counts freely, set lets the gate start and stop counting.
// - gate polarity 0 counts while the gate is low, polarity 1 while it is high.
// - with the gate active each rising edge of the selected clock is counted.
// - with the gate inactive the count holds.
// - the gate source select field picks one of several gate sources.
module gst_timer #(
  parameter int GATE_SRC_N = 4
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // avalon-mm slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // pins and system
  input wire logic external_clock_pin_i,
  input wire logic [GATE_SRC_N-1:0] gate_input_i,
  input wire logic sleep_i,
  // status outputs
  output logic overflow_flag_o,
  output logic wake_o
);

  // -------------------------------------------------------------------------
  // elaboration check
  // -------------------------------------------------------------------------
  if (GATE_SRC_N < 1 || GATE_SRC_N > 4) begin : g_chk
    $error("GATE_SRC_N must be 1 to 4");
  end

  localparam int PW = $clog2(gst_pkg::GST_PHASE_DIV);
  localparam logic [PW-1:0] PHASE_LAST = PW'(gst_pkg::GST_PHASE_DIV - 1);

  // -------------------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------------------
  logic [GATE_SRC_N:0] pins_s;
  logic ext_s;
  logic [GATE_SRC_N-1:0] gate_s;

  gst_sync3 #(
    .WIDTH(GATE_SRC_N + 1)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .async_i({gate_input_i, external_clock_pin_i}),
    .level_o(pins_s)
  );

  assign ext_s = pins_s[0];
  assign gate_s = pins_s[GATE_SRC_N:1];

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  gst_pkg::gst_bus_t bus_state_r;
  gst_pkg::gst_bus_t bus_state_nxt;
  logic [31:0] rdata_nxt;
  logic wait_nxt;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] gate_r;
  logic [7:0] gate_nxt;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [2:0] pre_r;
  logic [2:0] pre_nxt;
  logic [PW-1:0] phase_r;
  logic [PW-1:0] phase_nxt;
  logic ext_prev_r;
  logic ext_pend_r;
  logic ext_pend_nxt;
  logic ovf_nxt;
  logic wake_nxt;

  // -------------------------------------------------------------------------
  // address decode
  // -------------------------------------------------------------------------
  logic hit_stat;
  logic hit_lo;
  logic hit_hi;
  logic hit_ctrl;
  logic hit_gate;
  logic wr_commit;

  assign hit_stat = avs_address_i == {gst_pkg::GST_IDX_STATUS[5:0], 2'b00};
  assign hit_lo = avs_address_i == {gst_pkg::GST_IDX_COUNT_LO[5:0], 2'b00};
  assign hit_hi = avs_address_i == {gst_pkg::GST_IDX_COUNT_HI[5:0], 2'b00};
  assign hit_ctrl = avs_address_i == {gst_pkg::GST_IDX_CTRL[5:0], 2'b00};
  assign hit_gate = avs_address_i == {gst_pkg::GST_IDX_GATE[5:0], 2'b00};
  // a write takes effect at the edge where waitrequest is seen low
  assign wr_commit = avs_write_i && (bus_state_r == gst_pkg::GST_BUS_ANSWER);

  // -------------------------------------------------------------------------
  // control fields
  // -------------------------------------------------------------------------
  gst_pkg::gst_clksrc_t clk_sel;
  logic [1:0] ps_sel;
  logic [1:0] gate_sel;
  logic sync_bypass;
  logic counter_on;
  logic gate_enable_bit;
  logic gate_polarity;
  logic gate_level;
  logic ext_sel;
  logic async_mode;

  assign clk_sel = gst_pkg::gst_clksrc_t'(ctrl_r[gst_pkg::GST_CTRL_CS_LSB +: 2]);
  assign ps_sel = ctrl_r[gst_pkg::GST_CTRL_PS_LSB +: 2];
  assign sync_bypass = ctrl_r[gst_pkg::GST_CTRL_SYNC_BIT];
  assign counter_on = ctrl_r[gst_pkg::GST_CTRL_ON_BIT];
  assign gate_enable_bit = gate_r[gst_pkg::GST_GATE_EN_BIT];
  assign gate_polarity = gate_r[gst_pkg::GST_GATE_POL_BIT];
  assign gate_sel = gate_r[gst_pkg::GST_GATE_SS_LSB +: 2];
  assign ext_sel = clk_sel[1];
  // async mode stays in the system clock, its edges only skip the phase alignment
  assign async_mode = ext_sel && sync_bypass;

  // gate source mux, unused selections read as low
  always_comb begin
    gate_level = 1'b0;
    for (int i = 0; i < GATE_SRC_N; i++) begin
      if (gate_sel == 2'(i)) begin
        gate_level = gate_s[i];
      end
    end
  end

  // -------------------------------------------------------------------------
  // bus slave: answer one cycle after the request
  // -------------------------------------------------------------------------
  always_comb begin
    bus_state_nxt = gst_pkg::GST_BUS_IDLE;
    wait_nxt = 1'b1;
    rdata_nxt = avs_readdata_o;
    if (bus_state_r == gst_pkg::GST_BUS_IDLE && (avs_read_i || avs_write_i)) begin
      bus_state_nxt = gst_pkg::GST_BUS_ANSWER;
      wait_nxt = 1'b0;
    end
    // read data load only on a read and hold until the next read answer
    if (bus_state_r == gst_pkg::GST_BUS_IDLE && avs_read_i) begin
      rdata_nxt = 32'h0000_0000;
      // count bytes come from the sys-domain counter, so a read is whole
      if (hit_stat) begin
        rdata_nxt[gst_pkg::GST_STAT_OVF_BIT] = overflow_flag_o;
      end else if (hit_lo) begin
        rdata_nxt[7:0] = count_r[7:0];
      end else if (hit_hi) begin
        rdata_nxt[7:0] = count_r[15:8];
      end else if (hit_ctrl) begin
        rdata_nxt[7:0] = ctrl_r;
      end else if (hit_gate) begin
        rdata_nxt[7:0] = gate_r;
        rdata_nxt[gst_pkg::GST_GATE_VAL_BIT] = gate_level;
      end
    end
  end

  // bus answer registers
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_state_r <= gst_pkg::GST_BUS_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      bus_state_r <= bus_state_nxt;
      avs_waitrequest_o <= wait_nxt;
      avs_readdata_o <= rdata_nxt;
    end
  end

  // -------------------------------------------------------------------------
  // control registers
  // -------------------------------------------------------------------------
  // masked writes keep unused and read-only bits at zero
  always_comb begin
    ctrl_nxt = ctrl_r;
    gate_nxt = gate_r;
    if (wr_commit && hit_ctrl) begin
      ctrl_nxt = avs_writedata_i[7:0] & gst_pkg::GST_CTRL_WMASK;
    end
    if (wr_commit && hit_gate) begin
      gate_nxt = avs_writedata_i[7:0] & gst_pkg::GST_GATE_WMASK;
    end
  end

  // control registers load only from the bus
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_r <= gst_pkg::GST_CTRL_RST;
      gate_r <= gst_pkg::GST_GATE_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
      gate_r <= gate_nxt;
    end
  end

  // -------------------------------------------------------------------------
  // phase clock: a one-cycle enable every GST_PHASE_DIV system cycles
  // -------------------------------------------------------------------------
  logic phase_tick;

  // free-running divider, the pulse marks its last count
  always_comb begin
    phase_tick = phase_r == PHASE_LAST;
    phase_nxt = phase_tick ? '0 : PW'(phase_r + 1'b1);
  end

  // phase divider register
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_r <= '0;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // -------------------------------------------------------------------------
  // counter clock, prescaler, gate and count
  // -------------------------------------------------------------------------
  logic ext_rise;
  logic src_tick;
  logic run;
  logic pre_tick;
  logic [2:0] pre_last;
  logic inc;

  // edge detect, source select, gate, prescaler and count
  always_comb begin
    ext_rise = ext_s && !ext_prev_r;
    // synchronous mode holds an external edge until the phase pulse
    ext_pend_nxt = (ext_pend_r || ext_rise) && !phase_tick;
    unique case (clk_sel)
      gst_pkg::GST_CS_PHASE: src_tick = phase_tick;
      gst_pkg::GST_CS_SYS: src_tick = 1'b1;
      gst_pkg::GST_CS_EXT, gst_pkg::GST_CS_EXT_ALT: begin
        // switching bypass while edges arrive may drop or add one count
        if (sync_bypass) begin
          src_tick = ext_rise;
        end else begin
          src_tick = (ext_pend_r || ext_rise) && phase_tick;
        end
      end
    endcase
    // gate off or matching level lets edges through, sleep stops all but async
    run = counter_on && (!gate_enable_bit || (gate_level == gate_polarity))
          && (!sleep_i || async_mode);
    pre_tick = src_tick && run;
    pre_last = 3'((4'h1 << ps_sel) - 4'h1);
    inc = pre_tick && (pre_r == pre_last);
    pre_nxt = pre_r;
    if (pre_tick) begin
      pre_nxt = inc ? 3'h0 : 3'(pre_r + 3'h1);
    end
    count_nxt = inc ? 16'(count_r + 16'h0001) : count_r;
    ovf_nxt = overflow_flag_o || (inc && count_r == gst_pkg::GST_COUNT_MAX);
    if (wr_commit) begin
      if (hit_lo) begin
        count_nxt[7:0] = avs_writedata_i[7:0];
        pre_nxt = 3'h0;
      end
      if (hit_hi) begin
        count_nxt[15:8] = avs_writedata_i[7:0];
        pre_nxt = 3'h0;
      end
      // write one clears, a new overflow in the same cycle wins
      if (hit_stat && avs_writedata_i[gst_pkg::GST_STAT_OVF_BIT]) begin
        ovf_nxt = inc && count_r == gst_pkg::GST_COUNT_MAX;
      end
    end
    wake_nxt = ovf_nxt && sleep_i && async_mode;
  end

  // counter, prescaler, edge and flag registers
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_r <= gst_pkg::GST_COUNT_RST;
      pre_r <= 3'h0;
      ext_prev_r <= 1'b0;
      ext_pend_r <= 1'b0;
      overflow_flag_o <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      count_r <= count_nxt;
      pre_r <= pre_nxt;
      ext_prev_r <= ext_s;
      ext_pend_r <= ext_pend_nxt;
      overflow_flag_o <= ovf_nxt;
      wake_o <= wake_nxt;
    end
  end

endmodule

// file: hw/gst_pkg.sv
package gst_pkg;

  // -------------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // -------------------------------------------------------------------------
  localparam logic [7:0] GST_IDX_STATUS = 8'h0E;
  localparam logic [7:0] GST_IDX_COUNT_LO = 8'h0F;
  localparam logic [7:0] GST_IDX_COUNT_HI = 8'h10;
  localparam logic [7:0] GST_IDX_CTRL = 8'h11;
  localparam logic [7:0] GST_IDX_GATE = 8'h12;

  // -------------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------------
  localparam int GST_CTRL_CS_LSB = 6;
  localparam int GST_CTRL_PS_LSB = 4;
  localparam int GST_CTRL_SYNC_BIT = 2;
  localparam int GST_CTRL_ON_BIT = 0;
  localparam int GST_GATE_EN_BIT = 7;
  localparam int GST_GATE_POL_BIT = 6;
  localparam int GST_GATE_VAL_BIT = 2;
  localparam int GST_GATE_SS_LSB = 0;
  localparam int GST_STAT_OVF_BIT = 0;

  // -------------------------------------------------------------------------
  // writable masks and values after reset
  // -------------------------------------------------------------------------
  localparam logic [7:0] GST_CTRL_WMASK = 8'hF5;
  localparam logic [7:0] GST_GATE_WMASK = 8'hC3;
  localparam logic [7:0] GST_CTRL_RST = 8'h00;
  localparam logic [7:0] GST_GATE_RST = 8'h00;
  localparam logic [15:0] GST_COUNT_RST = 16'h0000;
  localparam logic [15:0] GST_COUNT_MAX = 16'hFFFF;

  // -------------------------------------------------------------------------
  // clock and counts
  // -------------------------------------------------------------------------
  localparam int GST_CLK_MHZ = 250;
  localparam int GST_PHASE_DIV = 4;

  // counter clock selections
  typedef enum logic [1:0] {
    GST_CS_PHASE = 2'b00,
    GST_CS_SYS = 2'b01,
    GST_CS_EXT = 2'b10,
    GST_CS_EXT_ALT = 2'b11
  } gst_clksrc_t;

  // bus slave states
  typedef enum logic [0:0] {
    GST_BUS_IDLE = 1'b0,
    GST_BUS_ANSWER = 1'b1
  } gst_bus_t;

endpackage

// file: hw/gst_sync3.sv
`timescale 1ns/1ps
module gst_sync3 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // asynchronous inputs and filtered levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] level_nxt;

  // a change is taken once the second and third stages agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      level_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : level_o[i];
    end
  end

  // three stage chain, first stage read only by the second
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      level_o <= '0;
    end else begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_o <= level_nxt;
    end
  end

endmodule

// file: tb/gst_timer_monitor.sv
`timescale 1ns/1ps
module gst_timer_monitor #(
  parameter int GATE_SRC_N = 4
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // bus
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // pins and status
  input wire logic external_clock_pin_i,
  input wire logic [GATE_SRC_N-1:0] gate_input_i,
  input wire logic sleep_i,
  input wire logic overflow_flag_o,
  input wire logic wake_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  // software clear of the overflow flag
  wire clr = avs_write_i && !avs_waitrequest_o && avs_address_i == 8'h38 && avs_writedata_i[0];

  a_answer_next: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("no answer one cycle after a request");
  a_wait_one: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer held longer than one cycle");
  a_idle_wait: assert property (!avs_read_i && !avs_write_i && avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer without a request");
  a_rdata_hold: assert property ($changed(avs_readdata_o) |-> avs_read_i && !avs_waitrequest_o)
    else $error("read data moved outside a read answer");
  a_upper_zero: assert property (avs_readdata_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_ctrl_rsvd: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == 8'h44 |->
    avs_readdata_o[3] == 1'b0 && avs_readdata_o[1] == 1'b0)
    else $error("control unused bits read as one");
  a_wake_cause: assert property (wake_o |-> overflow_flag_o && $past(sleep_i))
    else $error("wake without overflow in sleep");
  a_ovf_clear: assert property ($fell(overflow_flag_o) |-> $past(clr) || $past(clr, 2) || $past(clr, 3))
    else $error("overflow flag fell without a clear");

  c_ovf: cover property ($rose(overflow_flag_o));
  c_wake: cover property (wake_o);
  c_ctrl_wr: cover property (avs_write_i && !avs_waitrequest_o && avs_address_i == 8'h44);
endmodule

bind gst_timer gst_timer_monitor #(.GATE_SRC_N(GATE_SRC_N)) u_gst_timer_monitor (
  .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .external_clock_pin_i(external_clock_pin_i), .gate_input_i(gate_input_i),
  .sleep_i(sleep_i), .overflow_flag_o(overflow_flag_o), .wake_o(wake_o)
);

// file: tb/gst_pin_model.sv
`timescale 1ns/1ps
module gst_pin_model #(
  parameter int GATE_SRC_N = 4
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // commands from the bench
  input wire logic run_i,
  input wire logic [GATE_SRC_N-1:0] gate_lvl_i,
  // pins toward the timer
  output logic external_clock_pin_o,
  output logic [GATE_SRC_N-1:0] gate_input_o
);
  logic [3:0] ph_r;
  // pin clock of 16 system cycles, parked low between bursts
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ph_r <= 4'h0;
    end else begin
      ph_r <= run_i ? ph_r + 4'h1 : 4'h0;
    end
  end
  assign external_clock_pin_o = ph_r[3];
  // gate sources follow the commanded levels
  assign gate_input_o = gate_lvl_i;
endmodule

// file: tb/tb_gst_timer.sv
`timescale 1ns/1ps
module tb_gst_timer;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] ad = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic wt, ovf, wake, ext;
  logic sleep = 1'b0;
  logic run_en = 1'b0;
  logic [3:0] glvl = 4'h0;
  logic [3:0] gin;
  int err_count = 0;
  int n_checks = 0;

  // clock of 4 ns
  always #2 clk_sys_i = ~clk_sys_i;

  gst_timer u_gst_timer (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .avs_address_i(ad),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wt), .external_clock_pin_i(ext), .gate_input_i(gin), .sleep_i(sleep),
    .overflow_flag_o(ovf), .wake_o(wake));
  gst_pin_model u_gst_pin_model (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .run_i(run_en),
    .gate_lvl_i(glvl), .external_clock_pin_o(ext), .gate_input_o(gin));

  task automatic give_verdict;
    $display("errors %0d checks %0d", err_count, n_checks);
    if (err_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    n_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      err_count++;
      $display("unexpected at %0t: got %h, want %h..%h", $time, got, lo, hi);
    end
  endtask

  // one bus transfer, held until waitrequest is seen low
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    rd <= !w;
    wr <= w;
    ad <= a;
    wd <= {24'h0, d};
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (wt !== 1'b0 && n < 50);
    if (n >= 50) begin
      err_count++;
      give_verdict;
    end else begin
      q = rdat[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask

  // clear, count for a window, stop, then judge the low byte
  task automatic run(input logic [7:0] c, input int n, input logic [7:0] lo, input logic [7:0] hi);
    logic [7:0] q;
    acc(1'b1, 8'h3C, 8'h00, q);
    acc(1'b1, 8'h40, 8'h00, q);
    acc(1'b1, 8'h44, c, q);
    run_en <= c[7];
    repeat (n) @(posedge clk_sys_i);
    run_en <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    acc(1'b1, 8'h44, c & 8'hFE, q);
    acc(1'b0, 8'h3C, 8'h00, q);
    chk(q, lo, hi);
  endtask

  task automatic s_regs;
    logic [7:0] q;
    acc(1'b0, 8'h44, 8'h00, q);
    chk(q, 8'h00, 8'h00);
    acc(1'b0, 8'h48, 8'h00, q);
    chk(q, 8'h00, 8'h00);
    acc(1'b1, 8'h44, 8'hFE, q);
    acc(1'b0, 8'h44, 8'h00, q);
    chk(q, 8'hF4, 8'hF4);
    acc(1'b1, 8'h00, 8'hFF, q);
    acc(1'b0, 8'h00, 8'h00, q);
    chk(q, 8'h00, 8'h00);
  endtask

  task automatic s_presc;
    for (int p = 0; p < 4; p++) begin
      run({2'b01, p[1:0], 4'b0001}, 54, (8'h40 >> p) - 8'h02, (8'h40 >> p) + 8'h02);
    end
    run(8'h01, 54, 8'h0F, 8'h11);
  endtask

  // selected gate first inactive then active, other sources the opposite
  task automatic s_gate;
    logic [7:0] q;
    logic [3:0] g;
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 4; s++) begin
        g = 4'h1 << s;
        glvl <= p[0] ? ~g : g;
        acc(1'b1, 8'h48, {1'b1, p[0], 4'h0, s[1:0]}, q);
        repeat (8) @(posedge clk_sys_i);
        acc(1'b0, 8'h48, 8'h00, q);
        chk(q, {1'b1, p[0], 3'h0, !p[0], s[1:0]}, {1'b1, p[0], 3'h0, !p[0], s[1:0]});
        run(8'h41, 30, 8'h00, 8'h00);
        glvl <= ~glvl;
        repeat (8) @(posedge clk_sys_i);
        run(8'h41, 30, 8'h25, 8'h2B);
      end
    end
    glvl <= 4'h0;
    acc(1'b1, 8'h48, 8'h40, q);
    run(8'h41, 30, 8'h25, 8'h2B);
  endtask

  task automatic s_ext;
    logic [7:0] q;
    run(8'h81, 160, 8'h09, 8'h0B);
    run(8'hC1, 160, 8'h09, 8'h0B);
    run(8'h85, 160, 8'h09, 8'h0B);
    sleep <= 1'b1;
    run(8'h81, 160, 8'h00, 8'h00);
    acc(1'b1, 8'h3C, 8'hF8, q);
    acc(1'b1, 8'h40, 8'hFF, q);
    acc(1'b1, 8'h44, 8'h85, q);
    run_en <= 1'b1;
    repeat (160) @(posedge clk_sys_i);
    run_en <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    chk({7'h0, ovf}, 8'h01, 8'h01);
    chk({7'h0, wake}, 8'h01, 8'h01);
    acc(1'b1, 8'h44, 8'h84, q);
    acc(1'b0, 8'h3C, 8'h00, q);
    chk(q, 8'h01, 8'h03);
    acc(1'b0, 8'h40, 8'h00, q);
    chk(q, 8'h00, 8'h00);
    acc(1'b0, 8'h38, 8'h00, q);
    chk(q, 8'h01, 8'h01);
    acc(1'b1, 8'h38, 8'h01, q);
    sleep <= 1'b0;
    acc(1'b0, 8'h38, 8'h00, q);
    chk(q, 8'h00, 8'h00);
    chk({7'h0, ovf}, 8'h00, 8'h00);
  endtask

  initial begin
    repeat (8) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    s_regs;
    s_presc;
    s_gate;
    s_ext;
    give_verdict;
  end
endmodule
